/* include/charger_pkg.sv */
// Constants for the charge-setting register bank: offsets, resets, field
// positions, decode steps and watchdog timing.
// Assumes a 10 MHz sys_clk and an I2C slave that presents byte-wide
// register reads and writes on the device's internal register port.
package charger_pkg;
   // Register offsets on the internal port
   localparam logic [7:0] ADDR_LIMIT = 8'h02;
   localparam logic [7:0] ADDR_PRETERM = 8'h03;
   localparam logic [7:0] ADDR_VBAT = 8'h04;
   localparam logic [7:0] ADDR_CTRL1 = 8'h05;
   // Reset values
   localparam logic [7:0] RST_LIMIT = 8'h91;
   localparam logic [7:0] RST_PRETERM = 8'h12;
   localparam logic [7:0] RST_VBAT = 8'h40;
   localparam logic [7:0] RST_CTRL1 = 8'h9E;
   // Bits the watchdog restores, per register
   localparam logic [7:0] WD_MASK_LIMIT = 8'h3F;
   localparam logic [7:0] WD_MASK_ALL = 8'hFF;
   // Field positions
   localparam int FULL_ON_BIT = 6;
   localparam int FAST_MSB = 5;
   localparam int PRE_MSB = 7;
   localparam int PRE_LSB = 4;
   localparam int TERM_MSB = 3;
   localparam int VBAT_MSB = 7;
   localparam int VBAT_LSB = 3;
   localparam int TOPOFF_MSB = 2;
   localparam int TOPOFF_LSB = 1;
   localparam int WD_MSB = 5;
   localparam int WD_LSB = 4;
   // Fast charge decode
   localparam logic [10:0] FAST_STEP_MA = 11'h014;
   localparam logic [5:0] FAST_LINEAR_TOP = 6'h3B;
   localparam logic [10:0] FAST_3C_MA = 11'h50A;
   localparam logic [10:0] FAST_3D_MA = 11'h550;
   localparam logic [10:0] FAST_3E_MA = 11'h596;
   localparam logic [10:0] FAST_3F_MA = 11'h5DC;
   // Precharge and termination decode
   localparam logic [8:0] SMALL_STEP_MA = 9'h014;
   localparam logic [3:0] SMALL_CLAMP_CODE = 4'hC;
   // Input switch threshold
   localparam logic [11:0] FULL_ON_LIMIT_MA = 12'h2BC;
   // Regulation voltage decode
   localparam logic [4:0] VBAT_LINEAR_FIRST = 5'h09;
   localparam logic [12:0] VBAT_LINEAR_BASE_MV = 13'h10CC;
   localparam logic [12:0] VBAT_STEP_MV = 13'h000A;
   localparam logic [12:0] VBAT_DEFAULT_MV = 13'h1068;
   // Top-off and recharge
   localparam logic [5:0] TOPOFF_STEP_MIN = 6'h0F;
   localparam logic [7:0] RECHG_LOW_MV = 8'h78;
   localparam logic [7:0] RECHG_HIGH_MV = 8'hD2;
   // Watchdog timing
   localparam int unsigned CLOCK_HZ = 10000000;
   localparam int unsigned TICK_S = 1;
   localparam int unsigned TICK_CYCLES_DEF = CLOCK_HZ * TICK_S;
   localparam logic [7:0] WD_40_S = 8'h28;
   localparam logic [7:0] WD_80_S = 8'h50;
   localparam logic [7:0] WD_160_S = 8'hA0;
endpackage

/* logic/charger_current_voltage_regs.sv */
// Charge-setting register bank: four byte registers and their decoded
// currents, voltages and timer choices for the charging logic.
// Assumes the I2C slave gives one-cycle read/write strobes on sys_clk and
// the reset command arrives as a one-cycle pulse from the same domain.
`timescale 1ns/1ps
module charger_current_voltage_regs #(
   parameter int unsigned TICK_CYCLES = charger_pkg::TICK_CYCLES_DEF
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic reg_reset_cmd,
   input wire logic charge_request,
   input wire logic buck_mode,
   input wire logic [11:0] input_current_limit_ma,
   output logic [7:0] rd_data_q,
   output logic [10:0] fast_charge_current_q,
   output logic charge_enable_q,
   output logic input_switch_full_on_q,
   output logic [8:0] precharge_current_q,
   output logic [8:0] termination_current_q,
   output logic [12:0] battery_regulation_voltage_q,
   output logic topoff_enable_q,
   output logic [5:0] topoff_duration_q,
   output logic [7:0] recharge_threshold_q,
   output logic [7:0] control_one_q,
   output logic watchdog_expired_q
);
   import charger_pkg::*;

   // Four-bit current with 20 mA offset, clamped at code 1100
   function automatic logic [8:0] small_current(input logic [3:0] c);
      logic [3:0] k;
      k = (c > SMALL_CLAMP_CODE) ? SMALL_CLAMP_CODE : c;
      small_current = SMALL_STEP_MA + SMALL_STEP_MA * {5'h00, k};
   endfunction

   // Fast charge code to milliamps
   function automatic logic [10:0] fast_current(input logic [5:0] c);
      case (c)
         6'h3C: fast_current = FAST_3C_MA;
         6'h3D: fast_current = FAST_3D_MA;
         6'h3E: fast_current = FAST_3E_MA;
         6'h3F: fast_current = FAST_3F_MA;
         default: fast_current = FAST_STEP_MA * {5'h00, c};
      endcase
   endfunction

   // Regulation voltage code to millivolts
   function automatic logic [12:0] vbat_mv(input logic [4:0] c);
      case (c)
         5'h00: vbat_mv = 13'h0DB0;
         5'h01: vbat_mv = 13'h0E10;
         5'h02: vbat_mv = 13'h0E70;
         5'h03: vbat_mv = 13'h0ED8;
         5'h04: vbat_mv = 13'h0F40;
         5'h05: vbat_mv = 13'h0FA0;
         5'h06: vbat_mv = 13'h1004;
         5'h07: vbat_mv = 13'h1036;
         5'h08: vbat_mv = VBAT_DEFAULT_MV;
         default: vbat_mv = VBAT_LINEAR_BASE_MV
            + VBAT_STEP_MV * {8'h00, c - VBAT_LINEAR_FIRST};
      endcase
   endfunction

   logic [7:0] limit_q; // Charge current limit register
   logic [7:0] preterm_q; // Precharge and termination register
   logic [7:0] vbat_q; // Battery voltage limit register
   logic [7:0] ctrl1_q; // Charger control one register
   logic wd_expire; // One-cycle watchdog expiry

   // Address decode
   wire logic hit_limit = (reg_addr == ADDR_LIMIT);
   wire logic hit_preterm = (reg_addr == ADDR_PRETERM);
   wire logic hit_vbat = (reg_addr == ADDR_VBAT);
   wire logic hit_ctrl1 = (reg_addr == ADDR_CTRL1);
   // Read mux; unmapped offsets read as zero
   wire logic [7:0] rd_mux = hit_limit ? limit_q : hit_preterm ? preterm_q
      : hit_vbat ? vbat_q : hit_ctrl1 ? ctrl1_q : 8'h00;

   // Reset command beats watchdog, watchdog beats a host write
   // Every input is an argument, so the assigns below wake on each change
   function automatic logic [7:0] next_val(input logic [7:0] cur,
      input logic [7:0] rst, input logic [7:0] wd_mask, input logic wr,
      input logic rcmd, input logic wdx, input logic [7:0] wd_data);
      if (rcmd) next_val = rst;
      else if (wdx) next_val = (cur & ~wd_mask) | (rst & wd_mask);
      else if (wr) next_val = wd_data;
      else next_val = cur;
   endfunction

   wire logic [7:0] limit_d = next_val(limit_q, RST_LIMIT, WD_MASK_LIMIT,
      reg_write && hit_limit, reg_reset_cmd, wd_expire, reg_wdata);
   wire logic [7:0] preterm_d = next_val(preterm_q, RST_PRETERM, WD_MASK_ALL,
      reg_write && hit_preterm, reg_reset_cmd, wd_expire, reg_wdata);
   wire logic [7:0] vbat_d = next_val(vbat_q, RST_VBAT, WD_MASK_ALL,
      reg_write && hit_vbat, reg_reset_cmd, wd_expire, reg_wdata);
   wire logic [7:0] ctrl1_d = next_val(ctrl1_q, RST_CTRL1, WD_MASK_ALL,
      reg_write && hit_ctrl1, reg_reset_cmd, wd_expire, reg_wdata);

   // Field extraction
   wire logic [5:0] fast_code = limit_q[FAST_MSB:0];
   wire logic [3:0] pre_code = preterm_q[PRE_MSB:PRE_LSB];
   wire logic [3:0] term_code = preterm_q[TERM_MSB:0];
   wire logic [4:0] vbat_code = vbat_q[VBAT_MSB:VBAT_LSB];
   wire logic [1:0] topoff_code = vbat_q[TOPOFF_MSB:TOPOFF_LSB];
   // forced full-on at or above 700 mA
   wire logic full_on_d = !buck_mode || limit_q[FULL_ON_BIT]
      || (input_current_limit_ma >= FULL_ON_LIMIT_MA);

   // Register storage
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         limit_q <= RST_LIMIT;
         preterm_q <= RST_PRETERM;
         vbat_q <= RST_VBAT;
         ctrl1_q <= RST_CTRL1;
      end else begin
         limit_q <= limit_d;
         preterm_q <= preterm_d;
         vbat_q <= vbat_d;
         ctrl1_q <= ctrl1_d;
      end
   end

   // Read data held until the next read
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) rd_data_q <= 8'h00;
      else if (reg_read) rd_data_q <= rd_mux;
   end

   // Decoded settings, one cycle behind the registers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         fast_charge_current_q <= '0;
         charge_enable_q <= 1'b0;
         input_switch_full_on_q <= 1'b0;
         precharge_current_q <= '0;
         termination_current_q <= '0;
         battery_regulation_voltage_q <= '0;
         topoff_enable_q <= 1'b0;
         topoff_duration_q <= '0;
         recharge_threshold_q <= '0;
         control_one_q <= RST_CTRL1;
      end else begin
         fast_charge_current_q <= fast_current(fast_code);
         charge_enable_q <= charge_request && (fast_code != 6'h00);
         input_switch_full_on_q <= full_on_d;
         precharge_current_q <= small_current(pre_code);
         termination_current_q <= small_current(term_code);
         battery_regulation_voltage_q <= vbat_mv(vbat_code);
         topoff_enable_q <= (topoff_code != 2'b00);
         topoff_duration_q <= TOPOFF_STEP_MIN * {4'h0, topoff_code};
         recharge_threshold_q <= vbat_q[0] ? RECHG_HIGH_MV : RECHG_LOW_MV;
         control_one_q <= ctrl1_q;
      end
   end

   host_watchdog #(.TICK_CYCLES(TICK_CYCLES)) u_wd (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .wd_setting(ctrl1_q[WD_MSB:WD_LSB]),
      .kick(reg_write || reg_read || reg_reset_cmd),
      .expire_q(wd_expire)
   );
   assign watchdog_expired_q = wd_expire;

   property p_fast_linear;
      @(posedge sys_clk) disable iff (!reset_n)
      (fast_code <= FAST_LINEAR_TOP) |=>
         (fast_charge_current_q == FAST_STEP_MA * {5'h00, $past(fast_code)});
   endproperty
   a_fast_linear: assert property (p_fast_linear)
      else $error("fast charge linear decode wrong");

   property p_fast_top;
      @(posedge sys_clk) disable iff (!reset_n)
      (fast_code == 6'h3F) |=> (fast_charge_current_q == FAST_3F_MA);
   endproperty
   a_fast_top: assert property (p_fast_top)
      else $error("top fast charge code not 1500 mA");

   property p_zero_blocks;
      @(posedge sys_clk) disable iff (!reset_n)
      (fast_code == 6'h00) |=> !charge_enable_q;
   endproperty
   a_zero_blocks: assert property (p_zero_blocks)
      else $error("charging enabled with zero current");

   property p_full_on_high;
      @(posedge sys_clk) disable iff (!reset_n)
      (buck_mode && input_current_limit_ma >= FULL_ON_LIMIT_MA) |=> input_switch_full_on_q;
   endproperty
   a_full_on_high: assert property (p_full_on_high)
      else $error("switch not full on above threshold");

   property p_pre_clamp;
      @(posedge sys_clk) disable iff (!reset_n)
      (pre_code > SMALL_CLAMP_CODE) |=> (precharge_current_q == small_current(SMALL_CLAMP_CODE));
   endproperty
   a_pre_clamp: assert property (p_pre_clamp)
      else $error("precharge current not clamped");

   property p_term_clamp;
      @(posedge sys_clk) disable iff (!reset_n)
      (term_code > SMALL_CLAMP_CODE) |=> (termination_current_q == 9'h104);
   endproperty
   a_term_clamp: assert property (p_term_clamp)
      else $error("termination current not clamped");

   property p_reset_default_vbat;
      @(posedge sys_clk) disable iff (!reset_n)
      reg_reset_cmd |=> (vbat_q == RST_VBAT) ##1 (battery_regulation_voltage_q == VBAT_DEFAULT_MV);
   endproperty
   a_reset_default_vbat: assert property (p_reset_default_vbat)
      else $error("regulation voltage default wrong");

   property p_vbat_top;
      @(posedge sys_clk) disable iff (!reset_n)
      (vbat_code == 5'h1F) |=> (battery_regulation_voltage_q == 13'h11A8);
   endproperty
   a_vbat_top: assert property (p_vbat_top)
      else $error("top regulation code not 4.520 V");

   property p_wd_keeps_full_on;
      @(posedge sys_clk) disable iff (!reset_n)
      (wd_expire && !reg_reset_cmd) |=> (limit_q[FULL_ON_BIT] == $past(limit_q[FULL_ON_BIT]))
         && (preterm_q == RST_PRETERM);
   endproperty
   a_wd_keeps_full_on: assert property (p_wd_keeps_full_on)
      else $error("watchdog restore wrong");
endmodule

/* logic/host_watchdog.sv */
// Host watchdog: counts whole seconds since the last register access.
// Assumes kick comes from logic on sys_clk; one-second ticks come from
// an internal prescaler enable.
`timescale 1ns/1ps
module host_watchdog #(
   parameter int unsigned TICK_CYCLES = charger_pkg::TICK_CYCLES_DEF
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [1:0] wd_setting,
   input wire logic kick,
   output logic expire_q
);
   import charger_pkg::*;
   localparam int PW = $clog2(TICK_CYCLES + 1);
   localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYCLES - 1);

   // Timeout in seconds for a setting; zero means disabled
   function automatic logic [7:0] wd_seconds(input logic [1:0] s);
      case (s)
         2'b01: wd_seconds = WD_40_S;
         2'b10: wd_seconds = WD_80_S;
         2'b11: wd_seconds = WD_160_S;
         default: wd_seconds = 8'h00;
      endcase
   endfunction

   logic [PW-1:0] pre_q; // Prescaler toward one second
   logic [7:0] sec_q; // Whole seconds elapsed
   wire logic [7:0] limit_s = wd_seconds(wd_setting);
   wire logic enabled = (limit_s != 8'h00);
   wire logic tick = (pre_q == TICK_LAST);
   // Last second ending; expiry pulses for exactly one cycle
   wire logic hit = enabled && tick && (sec_q == limit_s - 8'h01);

   // Prescaler and second counter restart on any host access
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pre_q <= '0;
         sec_q <= 8'h00;
      end else if (kick || !enabled || hit) begin
         pre_q <= '0;
         sec_q <= 8'h00;
      end else if (tick) begin
         pre_q <= '0;
         sec_q <= sec_q + 8'h01;
      end else begin
         pre_q <= pre_q + PW'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) expire_q <= 1'b0;
      else expire_q <= hit && !kick;
   end

   property p_wd_off_quiet;
      @(posedge sys_clk) disable iff (!reset_n)
      (wd_setting == 2'b00) [*2] |-> !expire_q;
   endproperty
   a_wd_off_quiet: assert property (p_wd_off_quiet)
      else $error("watchdog expired while disabled");
endmodule

/* verif/charger_current_voltage_regs_tb.sv */
// Self-checking bench for the charge-setting register bank.
// Assumes the host model owns the register port; the bench drives the rest.
`timescale 1ns/1ps
module charger_current_voltage_regs_tb;
   import charger_pkg::*;
   // Four-cycle seconds keep the watchdog run short
   localparam int unsigned TICKS = 4;
   localparam logic [7:0] RSTV [0:3] = '{RST_LIMIT, RST_PRETERM, RST_VBAT, RST_CTRL1};
   localparam logic [12:0] VLUT [0:8] = '{13'h0DB0, 13'h0E10, 13'h0E70, 13'h0ED8,
      13'h0F40, 13'h0FA0, 13'h1004, 13'h1036, 13'h1068};
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic reg_reset_cmd = 1'b0;
   logic charge_request = 1'b0;
   logic buck_mode = 1'b1;
   logic [11:0] input_current_limit_ma = 12'h000;
   logic [7:0] reg_addr, reg_wdata, rd_data_q, recharge, ctrl1;
   logic reg_write, reg_read, chg_en, full_on, top_en, wd_exp;
   logic [10:0] fast;
   logic [8:0] pre, term;
   logic [12:0] vbat;
   logic [5:0] top_dur;
   int bad_count = 0;
   int total_checks = 0;
   int seed = 12;
   // Clock generator, 100 ns period
   always #50 sys_clk = ~sys_clk;
   charger_current_voltage_regs #(.TICK_CYCLES(TICKS)) u_dut (.sys_clk(sys_clk),
      .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_reset_cmd(reg_reset_cmd),
      .charge_request(charge_request), .buck_mode(buck_mode),
      .input_current_limit_ma(input_current_limit_ma), .rd_data_q(rd_data_q),
      .fast_charge_current_q(fast), .charge_enable_q(chg_en),
      .input_switch_full_on_q(full_on), .precharge_current_q(pre),
      .termination_current_q(term), .battery_regulation_voltage_q(vbat),
      .topoff_enable_q(top_en), .topoff_duration_q(top_dur),
      .recharge_threshold_q(recharge), .control_one_q(ctrl1),
      .watchdog_expired_q(wd_exp));
   reg_host_model u_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .rd_data_q(rd_data_q));
   // Fast charge: linear codes, then the four top entries
   function automatic logic [10:0] fast_exp(input logic [5:0] c);
      case (c)
         6'h3C: return 11'h50A;
         6'h3D: return 11'h550;
         6'h3E: return 11'h596;
         6'h3F: return 11'h5DC;
         default: return 11'(c) * 11'h014;
      endcase
   endfunction
   // Precharge and termination share the clamped offset decode
   function automatic logic [8:0] small_exp(input logic [3:0] c);
      return ((c > 4'hC) ? 9'h00D : 9'(c) + 9'h001) * 9'h014;
   endfunction
   // Regulation voltage: table below code 9, linear above
   function automatic logic [12:0] vbat_exp(input logic [4:0] c);
      return (c < 5'h09) ? VLUT[c] : 13'h10CC + (13'(c) - 13'h0009) * 13'h000A;
   endfunction
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Hang guard, far beyond the expected run of about 950 cycles
   initial begin
      #2000000;
      bad_count++;
      conclude();
   end
   initial begin
      logic [7:0] rv;
      logic [7:0] d;
      int n;
      repeat (8) @(posedge sys_clk);
      #1 reset_n = 1'b1;
      for (int i = 0; i < 4; i++) begin
         u_host.rd(8'h02 + 8'(i), rv);
         chk("reset_value", 16'(RSTV[i]), 16'(rv));
      end
      // Unmapped slots read back zero
      u_host.rd(8'h06, rv);
      chk("unmapped", 16'h0000, 16'(rv));
      chk("fast_default", 16'h0154, 16'(fast));
      chk("pre_default", 16'h0028, 16'(pre));
      chk("term_default", 16'h003C, 16'(term));
      chk("vbat_default", 16'h1068, 16'(vbat));
      chk("topoff_default", 16'h0000, 16'({top_en, top_dur}));
      chk("rechg_default", 16'h0078, 16'(recharge));
      chk("ctrl1_default", 16'h009E, 16'(ctrl1));
      $display("Test reset done");
      // every fast charge code, random enable request
      for (int i = 0; i < 64; i++) begin
         charge_request = 1'($random(seed));
         u_host.wr(ADDR_LIMIT, {1'($random(seed)), 1'b0, 6'(i)});
         @(posedge sys_clk);
         #1;
         chk("fast", 16'(fast_exp(6'(i))), 16'(fast));
         chk("chg_en", 16'(charge_request && i != 0), 16'(chg_en));
      end
      $display("Test fast charge done");
      for (int i = 0; i < 16; i++) begin
         u_host.wr(ADDR_PRETERM, {4'(i), 4'(15 - i)});
         @(posedge sys_clk);
         #1;
         chk("pre", 16'(small_exp(4'(i))), 16'(pre));
         chk("term", 16'(small_exp(4'(15 - i))), 16'(term));
      end
      $display("Test precharge termination done");
      // every voltage code, random timer and offset
      for (int i = 0; i < 32; i++) begin
         d = {5'(i), 3'($random(seed))};
         u_host.wr(ADDR_VBAT, d);
         @(posedge sys_clk);
         #1;
         chk("vbat", 16'(vbat_exp(5'(i))), 16'(vbat));
         chk("topoff", 16'({d[2:1] != 2'b00, 6'(d[2:1]) * 6'h0F}), 16'({top_en, top_dur}));
         chk("rechg", d[0] ? 16'h00D2 : 16'h0078, 16'(recharge));
      end
      $display("Test voltage done");
      // switch mode against limit just under and at 700 mA
      for (int i = 0; i < 8; i++) begin
         buck_mode = i[2];
         input_current_limit_ma = i[1] ? 12'h2BC : 12'h2BB;
         u_host.wr(ADDR_LIMIT, {1'b1, i[0], 6'h11});
         @(posedge sys_clk);
         #1;
         chk("full_on", 16'(!i[2] || i[1] || i[0]), 16'(full_on));
      end
      $display("Test switch done");
      // reset command wins over a write in the same cycle
      fork
         u_host.wr(ADDR_LIMIT, 8'h3F);
         begin
            @(posedge sys_clk);
            #1 reg_reset_cmd = 1'b1;
            @(posedge sys_clk);
            #1 reg_reset_cmd = 1'b0;
         end
      join
      u_host.rd(ADDR_LIMIT, rv);
      chk("reset_cmd", 16'h0091, 16'(rv));
      // 40 s expiry keeps bits 7:6, restores the rest
      u_host.wr(ADDR_LIMIT, 8'hC5);
      u_host.wr(ADDR_VBAT, 8'hFF);
      n = 0;
      while (wd_exp !== 1'b1 && n < 300) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk("wd_window", 16'h0001, 16'(n >= 157 && n <= 163));
      @(posedge sys_clk);
      #1;
      chk("wd_pulse", 16'h0000, 16'(wd_exp));
      @(posedge sys_clk);
      #1;
      chk("wd_vbat", 16'h1068, 16'(vbat));
      u_host.rd(ADDR_LIMIT, rv);
      chk("wd_limit", 16'h00D1, 16'(rv));
      u_host.wr(ADDR_CTRL1, 8'h8E);
      n = 0;
      repeat (400) begin
         @(posedge sys_clk);
         #1;
         n += (wd_exp === 1'b1);
      end
      chk("wd_off", 16'h0000, 16'(n));
      chk("ctrl1", 16'h008E, 16'(ctrl1));
      $display("Test watchdog done");
      conclude();
   end
endmodule

/* verif/reg_host_model.sv */
// Host-side model of the internal register port, one-cycle strobes.
// Assumes the caller runs on sys_clk; strobes change 1 ns after an edge.
`timescale 1ns/1ps
module reg_host_model (
   input wire logic sys_clk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_write,
   output logic reg_read,
   input wire logic [7:0] rd_data_q
);
   // Idle port: strobes low, address parked on an unmapped slot
   initial begin
      reg_addr = 8'hFF;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end
   // Write: request held through exactly one sampling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_write = 1'b0;
      // Stale data inverted so nothing leans on a held value
      reg_wdata = ~d;
   endtask
   // Read: data registered at the taking edge, picked up just after it
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_read = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_read = 1'b0;
      d = rd_data_q;
   endtask
endmodule
